// file: core/monitor_pkg.sv
// Purpose: Shared constants and types for the shunt power monitor register block
// Assumes: 20 MHz core clock, 16-bit registers, 8-bit register index
// Notes: Conversion times are in ns; cycle counts derive from the clock period

package monitor_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_DROP = 8'h01;
  localparam logic [7:0] ADDR_SUPPLY = 8'h02;
  localparam logic [7:0] ADDR_POWER = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_SCALE = 8'h05;
  localparam logic [7:0] ADDR_ALERT_SEL = 8'h06;
  localparam logic [7:0] ADDR_ALERT_LIM = 8'h07;
  localparam logic [7:0] ADDR_IDENTITY = 8'hFF;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [15:0] SETUP_RESET = 16'h4127;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] SCALE_RESET = 16'h0000;
  localparam logic [15:0] ALERT_RESET = 16'h0000;
  localparam logic [15:0] ALERT_SEL_WMASK = 16'hFFE3;
  localparam int RESTORE_BIT = 15;
  localparam int AVG_LSB = 9;
  localparam int SUPPLY_CT_LSB = 6;
  localparam int DROP_CT_LSB = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_CONT_BIT = 2;
  localparam int MODE_SUPPLY_BIT = 1;
  localparam int MODE_DROP_BIT = 0;

  // ==========================================================================
  // Arithmetic scaling
  localparam int CURRENT_SHIFT = 11;
  localparam logic [31:0] POWER_DIVISOR = 32'h0000_4E20;

  // ==========================================================================
  // Conversion times
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned CT0_NS = 140000;
  localparam int unsigned CT1_NS = 204000;
  localparam int unsigned CT2_NS = 332000;
  localparam int unsigned CT3_NS = 588000;
  localparam int unsigned CT4_NS = 1100000;
  localparam int unsigned CT5_NS = 2116000;
  localparam int unsigned CT6_NS = 4156000;
  localparam int unsigned CT7_NS = 8224000;
  localparam int unsigned CT0_CYC = (CT0_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT1_CYC = (CT1_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT2_CYC = (CT2_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT3_CYC = (CT3_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT4_CYC = (CT4_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT5_CYC = (CT5_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT6_CYC = (CT6_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CT7_CYC = (CT7_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Measurement sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DROP = 4'h2,
    ST_SUPPLY = 4'h4,
    ST_CALC = 4'h8
  } state_e;

endpackage

// file: core/conv_timer.sv
// Purpose: Counts one conversion time selected by a 3-bit code
// Assumes: start is a one-cycle pulse from logic on core_clk
// Notes: A new start reloads the count, so an aborted conversion never ends early

`timescale 1ns/1ps

module conv_timer #(
  parameter int unsigned CYC0 = 2,
  parameter int unsigned CYC1 = 2,
  parameter int unsigned CYC2 = 2,
  parameter int unsigned CYC3 = 2,
  parameter int unsigned CYC4 = 2,
  parameter int unsigned CYC5 = 2,
  parameter int unsigned CYC6 = 2,
  parameter int unsigned CYC7 = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] code,
  output logic done
);

  typedef struct packed {
    logic [17:0] count;
    logic busy;
    logic done;
  } timer_s;

  timer_s cur;
  timer_s next_cur;

  // ==========================================================================
  // Countdown
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (start) begin
      next_cur.busy = 1'b1;
      case (code)
        3'h0: next_cur.count = 18'(CYC0 - 1);
        3'h1: next_cur.count = 18'(CYC1 - 1);
        3'h2: next_cur.count = 18'(CYC2 - 1);
        3'h3: next_cur.count = 18'(CYC3 - 1);
        3'h4: next_cur.count = 18'(CYC4 - 1);
        3'h5: next_cur.count = 18'(CYC5 - 1);
        3'h6: next_cur.count = 18'(CYC6 - 1);
        default: next_cur.count = 18'(CYC7 - 1);
      endcase
    end else if (cur.busy) begin
      if (cur.count == 18'h00000) begin
        next_cur.busy = 1'b0;
        next_cur.done = 1'b1;
      end else begin
        next_cur.count = cur.count - 18'h00001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done = cur.done;

  // ==========================================================================
  // Checks
  property p_done_single;
    @(posedge core_clk) disable iff (rst)
    cur.done |=> !cur.done;
  endproperty
  a_done_single: assert property (p_done_single) else $error("timer done longer than one cycle"); // RQ5

endmodule

// file: core/shunt_power_monitor_regs.sv
// Purpose: Measurement setup, averaging and result registers of a shunt power monitor
// Assumes: Register port and raw converter samples come from logic on core_clk
// Notes: Power magnitude is computed from the current magnitude; register read is one cycle
//
// Operation
// (RQ1) Reading the setup register changes no setting and no conversion.
// (RQ2) Writing setup at 00h halts conversion, then restarts with new contents.
// (RQ3) Writing one to setup bit 15 restores all defaults; bit self-clears.
// (RQ4) Setup bits 11:9 select 1 to 1024 averaged samples, default one.
// (RQ5) Setup bits 8:6 pick supply conversion time, default code 100.
// (RQ6) Setup bits 5:3 pick drop conversion time, same table, default 100.
// (RQ7) Setup bits 2:0 pick mode: off, triggered or continuous, default 111.
// (RQ8) Triggered runs one set per setup write; continuous repeats forever.
// (RQ9) Drop result is 16-bit two's complement, 2.5 uV per step.
// (RQ10) Drop result bit 15 marks negative; low bits carry the data.
// (RQ11) With averaging, result registers hold averaged values.
// (RQ12) Supply result step 1.25 mV; top bit always reads zero.
// (RQ13) Power step equals 25 times the current step.
// (RQ14) Power comes from current times supply result.
// (RQ15) That product is divided by 20000 for power.
// (RQ16) Current comes from signed drop value times scale factor.
// (RQ17) That product is divided by 2048 for current.
// (RQ18) Current is signed; negative drop gives negative current.
// (RQ19) Current and power stay zero until scale factor is written.
// (RQ20) Scale factor bits 14:0 set steps; all sixteen bits read and write.
// (RQ21) Reset values: setup 4127h, all other registers zero; identity at FFh reads CHIP_ID (5A01h).

`timescale 1ns/1ps

module shunt_power_monitor_regs #(
  parameter int unsigned CT2_CYC = monitor_pkg::CT2_CYC,
  parameter int unsigned CT3_CYC = monitor_pkg::CT3_CYC,
  parameter int unsigned CT4_CYC = monitor_pkg::CT4_CYC,
  parameter int unsigned CT5_CYC = monitor_pkg::CT5_CYC,
  parameter int unsigned CT6_CYC = monitor_pkg::CT6_CYC,
  parameter int unsigned CT7_CYC = monitor_pkg::CT7_CYC,
  // Arbitrary identity value
  parameter logic [15:0] CHIP_ID = 16'h5A01
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] drop_voltage,
  input wire logic [15:0] supply_voltage_input,
  output logic conv_start,
  output logic conv_supply,
  output logic [2:0] conv_time_sel,
  output logic conv_active
);

  typedef struct packed {
    monitor_pkg::state_e state;
    logic kick;
    logic [14:0] setup;
    logic [15:0] scale;
    logic [15:0] alert_sel;
    logic [15:0] alert_lim;
    logic [15:0] drop_res;
    logic [15:0] sup_res;
    logic [15:0] pwr_res;
    logic [15:0] cur_res;
    logic cal_written;
    logic signed [25:0] acc_drop;
    logic [25:0] acc_sup;
    logic [10:0] k;
    logic tstart;
    logic tsupply;
    logic [2:0] tcode;
    logic active;
    logic [15:0] rdata;
  } main_state_s;

  localparam main_state_s RESET_VAL = '{
    state: monitor_pkg::ST_IDLE,
    kick: 1'b1,
    setup: monitor_pkg::SETUP_RESET[14:0],
    scale: monitor_pkg::SCALE_RESET,
    alert_sel: monitor_pkg::ALERT_RESET,
    alert_lim: monitor_pkg::ALERT_RESET,
    drop_res: monitor_pkg::RESULT_RESET,
    sup_res: monitor_pkg::RESULT_RESET,
    pwr_res: monitor_pkg::RESULT_RESET,
    cur_res: monitor_pkg::RESULT_RESET,
    default: '0
  };

  main_state_s cur;
  main_state_s next_cur;
  logic timer_done;

  // ==========================================================================
  // Conversion timer
  conv_timer #(
    .CYC0(monitor_pkg::CT0_CYC),
    .CYC1(monitor_pkg::CT1_CYC),
    .CYC2(CT2_CYC),
    .CYC3(CT3_CYC),
    .CYC4(CT4_CYC),
    .CYC5(CT5_CYC),
    .CYC6(CT6_CYC),
    .CYC7(CT7_CYC)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(cur.tstart),
    .code(cur.tcode),
    .done(timer_done)
  );

  function automatic logic [3:0] avg_shift(input logic [2:0] sel);
    case (sel)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction

  // ==========================================================================
  // Sequencer, arithmetic and register file
  always_comb begin
    logic [2:0] mode;
    logic [2:0] sample_count_sel;
    logic [2:0] supply_conv_time;
    logic [2:0] drop_conv_time;
    logic [3:0] sh;
    logic [10:0] k_last;
    logic signed [25:0] sum_drop;
    logic [25:0] sum_sup;
    logic signed [25:0] avg_drop;
    logic [25:0] avg_sup;
    logic [15:0] drop_value;
    logic [15:0] supply_value;
    logic signed [31:0] cur_prod;
    logic [15:0] scale_value;
    logic [15:0] cur_mag;
    logic [31:0] pwr_prod;
    logic [31:0] power_value;
    mode = '0;
    sample_count_sel = '0;
    supply_conv_time = '0;
    drop_conv_time = '0;
    sh = '0;
    k_last = '0;
    sum_drop = '0;
    sum_sup = '0;
    avg_drop = '0;
    avg_sup = '0;
    drop_value = '0;
    supply_value = '0;
    cur_prod = '0;
    scale_value = '0;
    cur_mag = '0;
    pwr_prod = '0;
    power_value = '0;
    next_cur = cur;
    next_cur.tstart = 1'b0;
    mode = cur.setup[monitor_pkg::MODE_LSB +: 3]; // RQ7
    sample_count_sel = cur.setup[monitor_pkg::AVG_LSB +: 3]; // RQ4
    supply_conv_time = cur.setup[monitor_pkg::SUPPLY_CT_LSB +: 3]; // RQ5
    drop_conv_time = cur.setup[monitor_pkg::DROP_CT_LSB +: 3]; // RQ6
    sh = avg_shift(sample_count_sel); // RQ4
    k_last = 11'((11'h001 << sh) - 11'h001);
    sum_drop = cur.acc_drop + {{10{drop_voltage[15]}}, drop_voltage};
    sum_sup = cur.acc_sup + {11'h000, supply_voltage_input[14:0]};
    avg_drop = cur.acc_drop >>> sh; // RQ11
    avg_sup = cur.acc_sup >> sh; // RQ11
    drop_value = mode[monitor_pkg::MODE_DROP_BIT] ? avg_drop[15:0] : cur.drop_res;
    supply_value = mode[monitor_pkg::MODE_SUPPLY_BIT] ? {1'b0, avg_sup[14:0]} : cur.sup_res; // RQ12
    scale_value = {1'b0, cur.scale[14:0]}; // RQ20
    cur_prod = $signed(drop_value) * $signed(scale_value); // RQ16
    cur_prod = cur_prod >>> monitor_pkg::CURRENT_SHIFT; // RQ17
    cur_mag = cur_prod[15] ? 16'(-cur_prod[15:0]) : cur_prod[15:0]; // RQ18
    pwr_prod = {16'h0000, cur_mag} * {16'h0000, supply_value}; // RQ14
    power_value = pwr_prod / monitor_pkg::POWER_DIVISOR; // RQ15 RQ13
    case (cur.state)
      monitor_pkg::ST_IDLE: begin
        next_cur.active = 1'b0;
        if (cur.kick) begin
          next_cur.kick = 1'b0;
          next_cur.acc_drop = '0;
          next_cur.acc_sup = '0;
          next_cur.k = '0;
          if (mode[1:0] != 2'h0) begin
            next_cur.active = 1'b1;
            next_cur.tstart = 1'b1; // RQ2
            next_cur.tsupply = !mode[monitor_pkg::MODE_DROP_BIT];
            next_cur.tcode = mode[monitor_pkg::MODE_DROP_BIT] ? drop_conv_time
                                                              : supply_conv_time;
            next_cur.state = mode[monitor_pkg::MODE_DROP_BIT] ? monitor_pkg::ST_DROP
                                                              : monitor_pkg::ST_SUPPLY;
          end
        end
      end
      monitor_pkg::ST_DROP: begin
        if (timer_done && !cur.tstart) begin
          next_cur.acc_drop = sum_drop;
          next_cur.tstart = 1'b1;
          if (mode[monitor_pkg::MODE_SUPPLY_BIT]) begin
            next_cur.tsupply = 1'b1;
            next_cur.tcode = supply_conv_time;
            next_cur.state = monitor_pkg::ST_SUPPLY;
          end else if (cur.k == k_last) begin
            next_cur.tstart = 1'b0;
            next_cur.state = monitor_pkg::ST_CALC;
          end else begin
            next_cur.k = cur.k + 11'h001;
            next_cur.tcode = drop_conv_time;
          end
        end
      end
      monitor_pkg::ST_SUPPLY: begin
        if (timer_done && !cur.tstart) begin
          next_cur.acc_sup = sum_sup;
          if (cur.k == k_last) begin
            next_cur.state = monitor_pkg::ST_CALC;
          end else begin
            next_cur.k = cur.k + 11'h001;
            next_cur.tstart = 1'b1;
            next_cur.tsupply = !mode[monitor_pkg::MODE_DROP_BIT];
            next_cur.tcode = mode[monitor_pkg::MODE_DROP_BIT] ? drop_conv_time
                                                              : supply_conv_time;
            next_cur.state = mode[monitor_pkg::MODE_DROP_BIT] ? monitor_pkg::ST_DROP
                                                              : monitor_pkg::ST_SUPPLY;
          end
        end
      end
      monitor_pkg::ST_CALC: begin
        next_cur.drop_res = drop_value; // RQ9 RQ10
        next_cur.sup_res = supply_value; // RQ12
        if (cur.cal_written) begin
          next_cur.cur_res = cur_prod[15:0]; // RQ18
          next_cur.pwr_res = power_value[15:0]; // RQ14
        end
        next_cur.kick = mode[monitor_pkg::MODE_CONT_BIT]; // RQ8
        next_cur.state = monitor_pkg::ST_IDLE;
      end
      default: begin
        next_cur.state = monitor_pkg::ST_IDLE;
      end
    endcase
    if (reg_wr) begin
      if (reg_addr == monitor_pkg::ADDR_SETUP) begin
        if (reg_wdata[monitor_pkg::RESTORE_BIT]) begin
          next_cur = RESET_VAL; // RQ3 RQ21
          next_cur.rdata = cur.rdata;
        end else begin
          next_cur.setup = reg_wdata[14:0]; // RQ4 RQ5 RQ6 RQ7
          next_cur.state = monitor_pkg::ST_IDLE; // RQ2
          next_cur.kick = 1'b1; // RQ2 RQ8
          next_cur.tstart = 1'b0;
          next_cur.active = 1'b0;
        end
      end else if (reg_addr == monitor_pkg::ADDR_SCALE) begin
        next_cur.scale = reg_wdata; // RQ20
        next_cur.cal_written = 1'b1; // RQ19
      end else if (reg_addr == monitor_pkg::ADDR_ALERT_SEL) begin
        next_cur.alert_sel = reg_wdata & monitor_pkg::ALERT_SEL_WMASK;
      end else if (reg_addr == monitor_pkg::ADDR_ALERT_LIM) begin
        next_cur.alert_lim = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == monitor_pkg::ADDR_SETUP) begin
        next_cur.rdata = {1'b0, cur.setup}; // RQ1 RQ3
      end else if (reg_addr == monitor_pkg::ADDR_DROP) begin
        next_cur.rdata = cur.drop_res;
      end else if (reg_addr == monitor_pkg::ADDR_SUPPLY) begin
        next_cur.rdata = cur.sup_res;
      end else if (reg_addr == monitor_pkg::ADDR_POWER) begin
        next_cur.rdata = cur.pwr_res;
      end else if (reg_addr == monitor_pkg::ADDR_CURRENT) begin
        next_cur.rdata = cur.cur_res;
      end else if (reg_addr == monitor_pkg::ADDR_SCALE) begin
        next_cur.rdata = cur.scale;
      end else if (reg_addr == monitor_pkg::ADDR_ALERT_SEL) begin
        next_cur.rdata = cur.alert_sel;
      end else if (reg_addr == monitor_pkg::ADDR_ALERT_LIM) begin
        next_cur.rdata = cur.alert_lim;
      end else if (reg_addr == monitor_pkg::ADDR_IDENTITY) begin
        next_cur.rdata = CHIP_ID;
      end else begin
        next_cur.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= RESET_VAL; // RQ21
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign conv_start = cur.tstart;
  assign conv_supply = cur.tsupply;
  assign conv_time_sel = cur.tcode;
  assign conv_active = cur.active;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic setup_wr;
  assign setup_wr = reg_wr && (reg_addr == monitor_pkg::ADDR_SETUP);

  property p_setup_read;
    reg_rd && !reg_wr |=> $stable(cur.setup) && $stable(cur.scale);
  endproperty
  a_setup_read: assert property (p_setup_read) else $error("read altered settings"); // RQ1

  property p_write_halt;
    setup_wr && !reg_wdata[15] |=> cur.state == monitor_pkg::ST_IDLE && cur.kick && !conv_active;
  endproperty
  a_write_halt: assert property (p_write_halt) else $error("setup write did not halt"); // RQ2

  property p_restart;
    cur.state == monitor_pkg::ST_IDLE && cur.kick && cur.setup[1:0] != 2'h0 && !reg_wr
    |=> conv_start && conv_active ##1 !conv_start;
  endproperty
  a_restart: assert property (p_restart) else $error("conversion did not restart"); // RQ2

  property p_restore;
    setup_wr && reg_wdata[15]
    |=> cur.setup == monitor_pkg::SETUP_RESET[14:0] && cur.scale == 16'h0000 && !cur.cal_written;
  endproperty
  a_restore: assert property (p_restore) else $error("soft restore failed"); // RQ3

  property p_setup_store;
    setup_wr && !reg_wdata[15] |=> {1'b0, cur.setup} == ($past(reg_wdata) & 16'h7FFF);
  endproperty
  a_setup_store: assert property (p_setup_store) else $error("setup not stored"); // RQ7

  property p_triggered_stop;
    cur.state == monitor_pkg::ST_CALC && !cur.setup[2] && !reg_wr
    |=> cur.state == monitor_pkg::ST_IDLE && !cur.kick ##1 !conv_active;
  endproperty
  a_triggered_stop: assert property (p_triggered_stop) else $error("triggered mode reran"); // RQ8

  property p_continuous;
    cur.state == monitor_pkg::ST_CALC && cur.setup[2] && !reg_wr |=> cur.kick;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous mode stopped"); // RQ8

  property p_supply_top;
    cur.sup_res[15] == 1'b0;
  endproperty
  a_supply_top: assert property (p_supply_top) else $error("supply top bit set"); // RQ12

  property p_uncal;
    !cur.cal_written |-> cur.cur_res == 16'h0000 && cur.pwr_res == 16'h0000;
  endproperty
  a_uncal: assert property (p_uncal) else $error("current or power before scale write"); // RQ19

  property p_current_sign;
    cur.cur_res[15] |-> cur.drop_res[15];
  endproperty
  a_current_sign: assert property (p_current_sign) else $error("current sign mismatch"); // RQ18

  property p_read_setup;
    reg_rd && reg_addr == monitor_pkg::ADDR_SETUP |=> reg_rdata[15] == 1'b0;
  endproperty
  a_read_setup: assert property (p_read_setup) else $error("restore bit read back"); // RQ3

  c_restart: cover property (setup_wr ##1 cur.kick ##1 conv_start);
  c_calc_cont: cover property (cur.state == monitor_pkg::ST_CALC && cur.setup[2]);
  c_calc_trig: cover property (cur.state == monitor_pkg::ST_CALC && !cur.setup[2]);
  c_restore: cover property (setup_wr && reg_wdata[15]);

endmodule

// file: dv/sample_source.sv
// Purpose: Converter stand-in feeding raw samples to the monitor block
// Assumes: Samples alternate between two values per channel on each start
// Notes: Outside its own conversion a channel shows the inverted value

`timescale 1ns/1ps

module sample_source (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic conv_supply,
  input wire logic conv_active,
  input wire logic [15:0] drop_a,
  input wire logic [15:0] drop_b,
  input wire logic [15:0] supply_a,
  input wire logic [15:0] supply_b,
  output logic [15:0] drop_voltage,
  output logic [15:0] supply_voltage_input
);
  // ==========================================================================
  // Sample selection
  logic drop_sel;
  logic supply_sel;
  logic [15:0] drop_now;
  logic [15:0] supply_now;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drop_sel <= 1'b0;
      supply_sel <= 1'b0;
    end else if (conv_start) begin
      if (conv_supply) begin
        supply_sel <= ~supply_sel;
      end else begin
        drop_sel <= ~drop_sel;
      end
    end
  end

  assign drop_now = drop_sel ? drop_a : drop_b;
  assign supply_now = supply_sel ? supply_a : supply_b;
  assign drop_voltage = (conv_active && !conv_supply) ? drop_now : ~drop_now;
  assign supply_voltage_input = (conv_active && conv_supply) ? supply_now : ~supply_now;
endmodule

// file: dv/shunt_power_monitor_regs_tb_top.sv
// Purpose: Register and measurement checks of the monitor block
// Assumes: Short conversion counts for codes 2 to 6
// Notes: Inputs change 2 ns after the rising edge

`timescale 1ns/1ps

module shunt_power_monitor_regs_tb_top;
  logic core_clk, rst, reg_wr, reg_rd, conv_start, conv_supply, conv_active;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, drop_voltage, supply_voltage_input, d0, d1, s0, s1;
  logic [2:0] conv_time_sel, exp_dct, exp_sct;
  int errors, n_compared, n_starts;

  // Short counts for codes 2 to 6; identity left at its default
  shunt_power_monitor_regs #(.CT2_CYC(20), .CT3_CYC(30), .CT4_CYC(40), .CT5_CYC(50),
    .CT6_CYC(60)) u_shunt_power_monitor_regs (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drop_voltage(drop_voltage),
    .supply_voltage_input(supply_voltage_input), .conv_start(conv_start),
    .conv_supply(conv_supply), .conv_time_sel(conv_time_sel), .conv_active(conv_active));

  sample_source u_sample_source (.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
    .conv_supply(conv_supply), .conv_active(conv_active), .drop_a(d0), .drop_b(d1),
    .supply_a(s0), .supply_b(s1), .drop_voltage(drop_voltage),
    .supply_voltage_input(supply_voltage_input));

  // ==========================================================================
  // Clock, watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    #1000000;
    errors++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #2;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #2;
    reg_rd = 1'b0;
    chk($sformatf("register %h", a), exp, reg_rdata);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic run(input logic [15:0] setup, input int starts);
    int i;
    wr(8'h00, setup);
    exp_dct = setup[5:3];
    exp_sct = setup[8:6];
    n_starts = 0;
    rd(8'h00, setup & 16'h7FFF);
    for (i = 0; i < 5000 && conv_active !== 1'b0; i++) cycles(1);
    chk("conv_active idle", 16'h0000, {15'h0, conv_active});
    chk("start count", 16'(starts), 16'(n_starts));
  endtask

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (conv_start === 1'b1) begin
      n_starts++;
      chk("conv_time_sel", {13'h0, conv_supply ? exp_sct : exp_dct}, {13'h0, conv_time_sel});
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    {errors, n_compared, n_starts} = '0;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 26'h0};
    {d0, d1, s0, s1} = '0;
    {exp_dct, exp_sct} = {3'h4, 3'h4};
    cycles(20);
    rst = 1'b0;
    for (int a = 0; a < 8; a++) rd(8'(a), a == 0 ? 16'h4127 : 16'h0000);
    rd(8'hFF, 16'h5A01);
    rd(8'h08, 16'h0000);
    wr(8'h01, 16'hFFFF);
    rd(8'h01, 16'h0000);
    wr(8'h06, 16'hFFFF);
    rd(8'h06, 16'hFFE3);
    wr(8'h07, 16'h1234);
    rd(8'h07, 16'h1234);
    wr(8'h05, 16'hFFFF);
    rd(8'h05, 16'hFFFF);
    wr(8'h05, 16'h0A00);
    {d0, d1, s0, s1} = {16'h1F40, 16'h1F40, 16'h2570, 16'h2570};
    run(16'h0093, 2);
    rd(8'h01, 16'h1F40);
    rd(8'h02, 16'h2570);
    rd(8'h04, 16'h2710);
    rd(8'h03, 16'h12B8);
    {d0, d1} = {16'hFC18, 16'hFC18};
    run(16'h0093, 2);
    rd(8'h01, 16'hFC18);
    rd(8'h04, 16'hFB1E);
    rd(8'h03, 16'h0257);
    {d0, d1, s0, s1} = {16'h0100, 16'h0200, 16'h1000, 16'h2000};
    run(16'h02D3, 8);
    rd(8'h01, 16'h0180);
    rd(8'h02, 16'h1800);
    rd(8'h04, 16'h01E0);
    rd(8'h03, 16'h0093);
    {s0, s1, d0, d1} = {16'hFFFF, 16'hFFFF, 16'h0010, 16'h0010};
    run(16'h0092, 1);
    rd(8'h02, 16'h7FFF);
    run(16'h0091, 1);
    rd(8'h01, 16'h0010);
    for (int m = 0; m < 8; m += 4) begin
      n_starts = 0;
      wr(8'h00, 16'(m));
      cycles(100);
      chk("power-down starts", 16'h0000, 16'(n_starts));
    end
    for (int m = 5; m < 8; m++) begin
      n_starts = 0;
      wr(8'h00, 16'h0090 | 16'(m));
      cycles(200);
      chk("continuous repeats", 16'h0001, {15'h0, n_starts >= 6});
    end
    wr(8'h00, 16'h0127);
    {exp_dct, exp_sct} = {3'h4, 3'h4};
    cycles(15);
    {d0, d1} = {16'h0222, 16'h0222};
    run(16'h0093, 2);
    rd(8'h01, 16'h0222);
    {d0, d1, exp_dct, exp_sct} = {16'h0400, 16'h0400, 3'h4, 3'h4};
    wr(8'h00, 16'h8000);
    rd(8'h00, 16'h4127);
    rd(8'h05, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'h07, 16'h0000);
    cycles(200);
    rd(8'h01, 16'h0400);
    rd(8'h04, 16'h0000);
    tally_and_finish();
  end
endmodule
